/* rtl/jcl_pkg.sv */
package jcl_pkg;

    // =========================================================
    // Register map (byte addresses)
    localparam logic [11:0] JCL_CTRL_ADDR   = 12'h000;
    localparam logic [11:0] JCL_STAT_ADDR   = 12'h004;
    localparam logic [11:0] JCL_IRQ_ADDR    = 12'h008;
    localparam logic [11:0] JCL_MASK_ADDR   = 12'h00c;
    localparam logic [11:0] JCL_WORDS_ADDR  = 12'h010;

    // =========================================================
    // Instruction codes, 4-bit instruction register
    localparam int          JCL_IR_W        = 4;
    localparam logic [3:0]  JCL_IR_BYPASS   = 4'hf;
    localparam logic [3:0]  JCL_IR_CONFIG   = 4'h2;
    localparam logic [3:0]  JCL_IR_STARTUP  = 4'h3;
    localparam logic [3:0]  JCL_IR_EXTEST   = 4'h0;
    localparam logic [3:0]  JCL_IR_SAMPLE   = 4'h5;
    localparam logic [1:0]  JCL_IR_CAPTURE  = 2'h1;

    // =========================================================
    // Field positions
    localparam int JCL_CTRL_ERR_BIT   = 0;
    localparam int JCL_CTRL_CHAIN_BIT = 1;
    localparam int JCL_IRQ_DONE_BIT   = 0;
    localparam int JCL_IRQ_ERR_BIT    = 1;
    localparam int JCL_IRQ_TEST_BIT   = 2;
    localparam int JCL_IRQ_W          = 3;

    // =========================================================
    // Configuration frame words at reset; load completes after the WORDS register count
    localparam logic [15:0] JCL_WORDS_RST = 16'h0004;
    localparam int          JCL_WORD_W    = 32;
    localparam logic [4:0]  JCL_BIT_LAST  = 5'h1f;

    typedef enum logic [3:0] {
        JCL_TLR, JCL_RTI, JCL_SEL_DR, JCL_CAP_DR, JCL_SH_DR, JCL_EX1_DR,
        JCL_PA_DR, JCL_EX2_DR, JCL_UPD_DR, JCL_SEL_IR, JCL_CAP_IR,
        JCL_SH_IR, JCL_EX1_IR, JCL_PA_IR, JCL_EX2_IR, JCL_UPD_IR
    } jcl_tap_e;

    typedef struct packed {
        logic tck;
        logic tms;
        logic tdi;
        logic trst_n;
    } jcl_jtag_s;

    typedef struct packed {
        logic err_low_o;
        logic err_low_oe;
        logic done_o;
        logic done_oe;
    } jcl_pins_s;

endpackage

/* rtl/jcl_loader.sv */
`timescale 1ns/1ns
module jcl_loader
    import jcl_pkg::*;
(
    input  wire logic        mclk,
    input  wire logic        rst_n,
    input  wire jcl_jtag_s   jtag,
    output logic             tdo_o,
    output logic             tdo_oe,
    input  wire logic        chain_enable_in_low,
    input  wire logic        reconfig_req_n,
    input  wire logic        chip_reset_n,
    input  wire logic        chip_oe,
    input  wire logic        other_load_busy,
    output logic             chain_enable_out_low,
    output jcl_pins_s        pins,
    output logic             load_complete_flag,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    output logic             irq
);

    // =========================================================
    // Pin synchronisers; test clock is sampled like data
    // Level pins idle as chain enabled, no abort, no other load
    localparam logic [2:0] PIN_IDLE = 3'h2;
    logic [3:0] s1_q, s2_q;
    logic [2:0] p1_q, p2_q;
    logic       tck_d1_q;
    always_ff @(posedge mclk or negedge rst_n)
        if (!rst_n)
        begin
            s1_q     <= 4'h0;
            s2_q     <= 4'h0;
            p1_q     <= PIN_IDLE;
            p2_q     <= PIN_IDLE;
            tck_d1_q <= 1'b0;
        end
        else
        begin
            s1_q     <= jtag;
            s2_q     <= s1_q;
            p1_q     <= {chain_enable_in_low, reconfig_req_n,
                         other_load_busy};
            p2_q     <= p1_q;
            tck_d1_q <= s2_q[3];
        end

    wire tck_s  = s2_q[3];
    wire tms_s  = s2_q[2];
    wire tdi_s  = s2_q[1];
    wire trst_s = s2_q[0];
    wire chain_s = p2_q[2];
    wire rcfg_s  = p2_q[1];
    wire obusy_s = p2_q[0];
    wire rise   = tck_s & ~tck_d1_q;
    wire fall   = ~tck_s & tck_d1_q;
    // Chip reset and output enable deliberately unused here
    wire unused = chip_reset_n ^ chip_oe;

    // =========================================================
    // TAP controller
    jcl_tap_e st_q, st_d;
    always_comb
    begin
        st_d = st_q;
        unique case (st_q)
            JCL_TLR:    st_d = tms_s ? JCL_TLR    : JCL_RTI;
            JCL_RTI:    st_d = tms_s ? JCL_SEL_DR : JCL_RTI;
            JCL_SEL_DR: st_d = tms_s ? JCL_SEL_IR : JCL_CAP_DR;
            JCL_CAP_DR: st_d = tms_s ? JCL_EX1_DR : JCL_SH_DR;
            JCL_SH_DR:  st_d = tms_s ? JCL_EX1_DR : JCL_SH_DR;
            JCL_EX1_DR: st_d = tms_s ? JCL_UPD_DR : JCL_PA_DR;
            JCL_PA_DR:  st_d = tms_s ? JCL_EX2_DR : JCL_PA_DR;
            JCL_EX2_DR: st_d = tms_s ? JCL_UPD_DR : JCL_SH_DR;
            JCL_UPD_DR: st_d = tms_s ? JCL_SEL_DR : JCL_RTI;
            JCL_SEL_IR: st_d = tms_s ? JCL_TLR    : JCL_CAP_IR;
            JCL_CAP_IR: st_d = tms_s ? JCL_EX1_IR : JCL_SH_IR;
            JCL_SH_IR:  st_d = tms_s ? JCL_EX1_IR : JCL_SH_IR;
            JCL_EX1_IR: st_d = tms_s ? JCL_UPD_IR : JCL_PA_IR;
            JCL_PA_IR:  st_d = tms_s ? JCL_EX2_IR : JCL_PA_IR;
            JCL_EX2_IR: st_d = tms_s ? JCL_UPD_IR : JCL_SH_IR;
            JCL_UPD_IR: st_d = tms_s ? JCL_SEL_DR : JCL_RTI;
        endcase
    end

    wire tap_rst  = ~trst_s;
    wire sh_dr    = (st_q == JCL_SH_DR);
    wire sh_ir    = (st_q == JCL_SH_IR);
    wire cap_dr   = (st_q == JCL_CAP_DR);

    // =========================================================
    // Instruction, bypass and configuration shift paths
    logic [3:0]  ir_sh_q, ir_q;
    logic        byp_q, tdo_q, oe_q;
    logic [31:0] cfg_sh_q;
    logic [4:0]  bit_q;
    logic [15:0] word_q, words_q;
    logic        busy_q, done_q, err_q, test_q, test_hit;

    wire is_byp  = (ir_q == JCL_IR_BYPASS);
    wire is_cfg  = (ir_q == JCL_IR_CONFIG);
    wire is_test = (ir_q == JCL_IR_EXTEST) | (ir_q == JCL_IR_SAMPLE);
    // Configuring needs chain enable low, no reconfigure request and no other load busy
    wire can_cfg = ~chain_s & rcfg_s
                   & ~obusy_s;
    wire cfg_bit = rise & sh_dr & is_cfg & can_cfg & ~done_q;
    wire word_end = cfg_bit & (bit_q == JCL_BIT_LAST);
    wire last_wd = word_end & (word_q == words_q - 16'h0001);
    // Error: reconfigure pulled, chain lost or other load busy mid-load
    wire bad_now = busy_q & ~can_cfg;
    assign test_hit = rise & (st_q == JCL_UPD_IR) & busy_q
                      & ((ir_sh_q == JCL_IR_EXTEST)
                      | (ir_sh_q == JCL_IR_SAMPLE));
    wire ser_out = sh_ir ? ir_sh_q[0] : is_byp ? byp_q
                 : is_cfg ? done_q : 1'b0;

    always_ff @(posedge mclk or negedge rst_n)
        if (!rst_n)
        begin
            st_q <= JCL_TLR;
            ir_sh_q <= 4'h0;
            ir_q <= JCL_IR_BYPASS;
            byp_q <= 1'b0;
        end
        else if (tap_rst)
        begin
            st_q <= JCL_TLR;
            ir_q <= JCL_IR_BYPASS;
        end
        else if (rise)
        begin
            st_q <= st_d;
            if (st_q == JCL_CAP_IR)
                ir_sh_q <= {2'h0, JCL_IR_CAPTURE};
            if (sh_ir)
                ir_sh_q <= {tdi_s, ir_sh_q[3:1]};
            // Test instruction refused during a load; bypass loaded instead
            if (st_q == JCL_UPD_IR)
                ir_q <= test_hit ? JCL_IR_BYPASS : ir_sh_q;
            if (st_q == JCL_TLR)
                ir_q <= JCL_IR_BYPASS;
            if (cap_dr && is_byp)
                byp_q <= 1'b0;
            if (sh_dr && is_byp)
                byp_q <= tdi_s;
        end

    // Output stage updates on falling test clock only
    always_ff @(posedge mclk or negedge rst_n)
        if (!rst_n)
        begin
            tdo_q <= 1'b0;
            oe_q <= 1'b0;
        end
        else if (fall)
        begin
            tdo_q <= ser_out;
            oe_q <= sh_dr | sh_ir;
        end

    assign tdo_o  = tdo_q;
    assign tdo_oe = oe_q;

    // =========================================================
    // Load progress
    logic err_ctl_q, chain_en_q;
    always_ff @(posedge mclk or negedge rst_n)
        if (!rst_n)
        begin
            cfg_sh_q <= 32'h0;
            bit_q <= 5'h0;
            word_q <= 16'h0;
            busy_q <= 1'b0;
            done_q <= 1'b0;
            err_q <= 1'b0;
        end
        else if (!rcfg_s)
        begin
            bit_q <= 5'h0;
            word_q <= 16'h0;
            busy_q <= 1'b0;
            done_q <= 1'b0;
            err_q <= busy_q | err_q;
        end
        else
        begin
            if (cfg_bit)
            begin
                cfg_sh_q <= {tdi_s, cfg_sh_q[31:1]};
                bit_q <= bit_q + 5'h1;
                busy_q <= ~last_wd;
            end
            if (word_end)
                word_q <= word_q + 16'h0001;
            if (last_wd)
                done_q <= 1'b1;
            if (bad_now)
            begin
                err_q <= 1'b1;
                busy_q <= 1'b0;
            end
        end

    assign load_complete_flag = done_q;
    // Chain enable out active when loaded, if chaining allowed
    assign chain_enable_out_low = ~(done_q & chain_en_q);
    // Open drain: drive low on error; done released when loaded
    assign pins.err_low_o  = 1'b0;
    assign pins.err_low_oe = err_q | err_ctl_q;
    assign pins.done_o     = 1'b0;
    assign pins.done_oe    = ~done_q;

    // =========================================================
    // APB slave, zero wait states
    logic [2:0] irq_q, mask_q;
    logic       done_d1_q, err_d1_q;
    wire acc  = psel & penable;
    wire wr   = acc & pwrite;
    wire w_ct = wr & (paddr == JCL_CTRL_ADDR);
    wire w_iq = wr & (paddr == JCL_IRQ_ADDR);
    wire w_mk = wr & (paddr == JCL_MASK_ADDR);
    wire w_wd = wr & (paddr == JCL_WORDS_ADDR);
    wire hit  = (paddr == JCL_CTRL_ADDR) | (paddr == JCL_STAT_ADDR)
              | (paddr == JCL_IRQ_ADDR) | (paddr == JCL_MASK_ADDR)
              | (paddr == JCL_WORDS_ADDR);
    wire [2:0] ev = {test_hit, err_q & ~err_d1_q, done_q & ~done_d1_q};

    always_ff @(posedge mclk or negedge rst_n)
        if (!rst_n)
        begin
            err_ctl_q <= 1'b0;
            chain_en_q <= 1'b1;
            mask_q <= 3'h0;
            irq_q <= 3'h0;
            words_q <= JCL_WORDS_RST;
            done_d1_q <= 1'b0;
            err_d1_q <= 1'b0;
        end
        else
        begin
            done_d1_q <= done_q;
            err_d1_q <= err_q;
            if (w_ct)
            begin
                err_ctl_q <= pwdata[JCL_CTRL_ERR_BIT];
                chain_en_q <= pwdata[JCL_CTRL_CHAIN_BIT];
            end
            if (w_mk)
                mask_q <= pwdata[JCL_IRQ_W-1:0];
            if (w_wd)
                words_q <= pwdata[15:0];
            // Set wins over a same-cycle clear
            irq_q <= (irq_q & ~(w_iq ? pwdata[JCL_IRQ_W-1:0] : 3'h0))
                   | ev;
        end

    wire [31:0] rd_mux =
        (paddr == JCL_CTRL_ADDR) ? {30'h0, chain_en_q, err_ctl_q} :
        (paddr == JCL_STAT_ADDR) ? {8'h0, word_q, ir_q,
                                    busy_q, err_q, done_q, test_q} :
        (paddr == JCL_IRQ_ADDR)  ? {29'h0, irq_q} :
        (paddr == JCL_MASK_ADDR) ? {29'h0, mask_q} :
        (paddr == JCL_WORDS_ADDR) ? {16'h0, words_q} : 32'h0;

    always_ff @(posedge mclk or negedge rst_n)
        if (!rst_n)
        begin
            prdata <= 32'h0;
            test_q <= 1'b0;
        end
        else
        begin
            test_q <= is_test;
            if (psel && !penable && !pwrite)
                prdata <= rd_mux;
        end

    assign pready  = 1'b1;
    assign pslverr = acc & ~hit;
    assign irq     = |(irq_q & mask_q);

endmodule

/* bench/jcl_loader_checker.sv */
`timescale 1ns/1ns
// ====
// Loader port checker
module jcl_loader_checker
    import jcl_pkg::*;
(
    input wire logic        mclk,
    input wire logic        rst_n,
    input wire jcl_jtag_s   jtag,
    input wire logic        tdo_o,
    input wire logic        chain_enable_out_low,
    input wire jcl_pins_s   pins,
    input wire logic        load_complete_flag,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic        pslverr,
    input wire logic        irq
);
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!rst_n);
    wire acc = psel && penable;
    wire mapped = paddr[1:0] == 2'h0 && paddr <= JCL_WORDS_ADDR;
    // Error pin must not blink: a host may poll it slowly
    sequence s_err_on;
        $rose(pins.err_low_oe);
    endsequence
    sequence s_loaded;
        $rose(load_complete_flag);
    endsequence
    // ====
    // Properties
    property p_map; acc |-> pslverr == !mapped; endproperty
    property p_pin; pins.done_oe == !load_complete_flag; endproperty
    property p_chain; s_loaded |-> ##[0:2] !chain_enable_out_low; endproperty
    property p_early; !chain_enable_out_low |-> load_complete_flag; endproperty
    property p_od; pins.err_low_o == 1'b0 && pins.done_o == 1'b0; endproperty
    property p_tdo; $changed(tdo_o) |-> !$past(jtag.tck, 2); endproperty
    property p_irq; $fell(irq) |-> $past(acc && pwrite); endproperty
    property p_err; s_err_on |=> pins.err_low_oe [*8]; endproperty
    a_map: assert property (p_map)
        else $error("slave error does not follow the map");
    a_pin: assert property (p_pin)
        else $error("done pin disagrees with load state");
    a_chain: assert property (p_chain)
        else $error("chain output not low after load");
    a_early: assert property (p_early)
        else $error("chain output low before load");
    a_od: assert property (p_od)
        else $error("open drain pin driven high");
    a_tdo: assert property (p_tdo)
        else $error("tdo moved outside a low test clock");
    a_irq: assert property (p_irq)
        else $error("interrupt dropped without a write");
    a_err: assert property (p_err)
        else $error("error pin released early");
endmodule

bind jcl_loader jcl_loader_checker chk_u (.*);

/* bench/jcl_jtag_host.sv */
`timescale 1ns/1ns
// ====
// Test-port host, one device in the chain
module jcl_jtag_host
    import jcl_pkg::*;
(
    input  wire logic mclk,
    output jcl_jtag_s jtag,
    input  wire logic tdo_o,
    input  wire logic tdo_oe
);
    // Tdo has no pull, so a read while released shows z
    wire  tdo_line = tdo_oe ? tdo_o : 1'bz;
    logic spare;
    initial jtag = '{tck: 1'b0, tms: 1'b1, tdi: 1'b1, trst_n: 1'b0};
    // ====
    // One 64 ns test clock; tck stands low between scans
    task tick(input logic ms, input logic di, output logic td);
        @(posedge mclk);
        jtag.tms <= ms;
        jtag.tdi <= di;
        repeat (3) @(posedge mclk);
        jtag.tck <= 1'b1;
        repeat (2) @(posedge mclk);
        td = tdo_line;
        repeat (2) @(posedge mclk);
        jtag.tck <= 1'b0;
    endtask
    // Only device on the chain, so nothing else to bypass
    task scan(input logic ir, input int n, input logic [31:0] din,
              output logic [31:0] dout, output logic oe_ok);
        dout = 32'h0;
        oe_ok = 1'b1;
        tick(1'b1, 1'b1, spare);
        if (ir)
            tick(1'b1, 1'b1, spare);
        tick(1'b0, 1'b1, spare);
        tick(1'b0, 1'b1, spare);
        for (int i = 0; i < n; i++)
        begin
            tick(i == n - 1, din[i], dout[i]);
            oe_ok = oe_ok & tdo_oe;
        end
        tick(1'b1, 1'b1, spare);
        tick(1'b0, 1'b1, spare);
    endtask
    task tap_reset();
        jtag.trst_n <= 1'b0;
        repeat (4) @(posedge mclk);
        jtag.trst_n <= 1'b1;
        tick(1'b0, 1'b1, spare);
    endtask
endmodule

/* bench/test_jcl_loader.sv */
`timescale 1ns/1ns
// ====
// Bench: reads queue a note, a monitor compares
module test_jcl_loader
    import jcl_pkg::*;
;
    logic        mclk = 1'b0;
    logic        rst_n = 1'b0;
    logic        reconfig_req_n = 1'b1;
    logic [1:0]  chip = 2'b11;
    logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h0;
    logic [31:0] pwdata = 32'h0, prdata, dout, din;
    logic        chain_in = 1'b0, other_busy = 1'b0;
    logic        tdo_o, tdo_oe, chain_enable_out_low, load_complete_flag;
    logic        pready, pslverr, irq, oe_ok;
    jcl_jtag_s   jtag;
    jcl_pins_s   pins;
    logic [64:0] exp_q[$];
    logic [64:0] e;
    logic [3:0]  codes[5] = '{JCL_IR_EXTEST, JCL_IR_SAMPLE, JCL_IR_STARTUP,
                              JCL_IR_CONFIG, JCL_IR_BYPASS};
    int          mismatches = 0, checks_done = 0, cyc = 0;
    always #4 mclk = ~mclk;
    always @(posedge mclk) chip <= 2'($urandom);
    jcl_loader dut_u (.mclk, .rst_n, .jtag, .tdo_o, .tdo_oe,
        .chain_enable_in_low(chain_in),
        .other_load_busy(other_busy),
        .reconfig_req_n, .chip_reset_n(chip[1]), .chip_oe(chip[0]),
        .chain_enable_out_low, .pins, .load_complete_flag, .psel, .penable,
        .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .irq);
    jcl_jtag_host host_u (.mclk, .jtag, .tdo_o, .tdo_oe);
    // ====
    // Checking and bus tasks
    task chk(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task print_verdict();
        if (mismatches == 0 && checks_done > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d,
             input logic [31:0] m = 32'hffffffff);
        @(posedge mclk);
        if (!w)
            exp_q.push_back({a > JCL_WORDS_ADDR, m, d & m});
        {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
        @(posedge mclk);
        penable <= 1'b1;
        @(posedge mclk);
        while (pready !== 1'b1)
            @(posedge mclk);
        {psel, penable} <= 2'b00;
    endtask
    task set_ir(input logic [3:0] c, input logic [3:0] now_ir);
        host_u.scan(1'b1, JCL_IR_W, {28'h0, c}, dout, oe_ok);
        chk(dout[1:0], JCL_IR_CAPTURE);
        chk({oe_ok, tdo_oe}, 2'b10);
        apb(1'b0, JCL_STAT_ADDR, {24'h0, now_ir, 3'h0,
            now_ir == JCL_IR_EXTEST || now_ir == JCL_IR_SAMPLE},
            32'hf1);
    endtask
    always @(posedge mclk)
        if (psel && penable && pready && !pwrite)
        begin
            e = exp_q.pop_front();
            chk(prdata & e[63:32], e[31:0]);
            chk(pslverr, e[64]);
        end
    // Ceiling is several times the expected run
    always @(posedge mclk)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            mismatches++;
            print_verdict();
        end
    end
    initial
    begin
        void'($urandom(32'h20ef));
        repeat (20) @(posedge mclk);
        rst_n <= 1'b1;
        host_u.tap_reset();
        apb(1'b0, JCL_CTRL_ADDR, 32'h2);
        apb(1'b0, JCL_WORDS_ADDR, {16'h0, JCL_WORDS_RST});
        apb(1'b0, JCL_IRQ_ADDR, 32'h0);
        apb(1'b0, JCL_MASK_ADDR, 32'h0);
        apb(1'b0, 12'h014, 32'h0);
        apb(1'b0, JCL_STAT_ADDR, {24'h0, JCL_IR_BYPASS, 4'h0}, 32'hfe);
        foreach (codes[i])
            set_ir(codes[i], codes[i]);
        din = {16'h0, 16'($urandom)};
        host_u.scan(1'b0, 16, din, dout, oe_ok);
        chk(dout[15:0], {din[14:0], 1'b0});
        // Refused test instruction, then an abort mid-load
        apb(1'b1, JCL_MASK_ADDR, 32'h7);
        set_ir(JCL_IR_CONFIG, JCL_IR_CONFIG);
        host_u.scan(1'b0, JCL_WORD_W, $urandom, dout, oe_ok);
        apb(1'b0, JCL_STAT_ADDR, 32'h8, 32'he);
        set_ir(JCL_IR_EXTEST, JCL_IR_BYPASS);
        apb(1'b0, JCL_IRQ_ADDR, 32'h4);
        apb(1'b1, JCL_IRQ_ADDR, 32'h4);
        @(posedge mclk);
        chk(irq, 1'b0);
        reconfig_req_n <= 1'b0;
        repeat (8) @(posedge mclk);
        reconfig_req_n <= 1'b1;
        repeat (4) @(posedge mclk);
        chk({pins.err_low_oe, load_complete_flag, irq}, 3'b101);
        // Second reset, then a clean load
        rst_n <= 1'b0;
        repeat (20) @(posedge mclk);
        rst_n <= 1'b1;
        host_u.tap_reset();
        apb(1'b1, JCL_MASK_ADDR, 32'h1);
        set_ir(JCL_IR_CONFIG, JCL_IR_CONFIG);
        // Blocked loads: chain disabled, then another scheme busy
        {chain_in, other_busy} <= 2'b10;
        host_u.scan(1'b0, JCL_WORD_W, $urandom, dout, oe_ok);
        {chain_in, other_busy} <= 2'b01;
        host_u.scan(1'b0, JCL_WORD_W, $urandom, dout, oe_ok);
        apb(1'b0, JCL_STAT_ADDR, 32'h0, 32'hffff08);
        {chain_in, other_busy} <= 2'b00;
        for (int w = 0; w < JCL_WORDS_RST; w++)
            host_u.scan(1'b0, JCL_WORD_W, $urandom, dout, oe_ok);
        repeat (4) @(posedge mclk);
        chk({load_complete_flag, pins.done_oe, irq}, 3'b101);
        chk(chain_enable_out_low, 1'b0);
        apb(1'b0, JCL_STAT_ADDR, 32'h2, 32'h6);
        host_u.scan(1'b0, 1, 32'h0, dout, oe_ok);
        chk(dout[0], 1'b1);
        set_ir(JCL_IR_SAMPLE, JCL_IR_SAMPLE);
        repeat (4) @(posedge mclk);
        print_verdict();
    end
endmodule
